// ===== rtl/pwm_gen_pkg.sv
// constants and types shared by the dual channel pulse width generator
// Notes on behaviour
// - fixed period, high time from current width
// - started channel runs until stopped, run mode is left or the generator is lost
// - width scale: 100, 1000, 10000 or 27648
// - zero holds low, full scale holds high
// - generator is width mode or train mode
// - channel one pin0, channel two pin2
// - output source selects onboard or add-on bank
// - cycle counted in milliseconds or microseconds
// - cycle time is static, not runtime changeable
// - width comes from writable dedicated word
// - stop to run reloads initial width
// - enabled call: 1 starts, 0 stops channel
// - busy always reads false
// - bad identifier gives 80A1, clears enable-out
// - generator pins ignore force requests
// - user writes never reach generator pins
package pwm_gen_pkg;

   // ------------------------------------------------------------
   // geometry
   // ------------------------------------------------------------
   localparam int CHANNELS      = 2;
   localparam int BANK_PINS     = 4;
   localparam int WORD_W        = 16;
   localparam int CH_ONE_PIN    = 0;
   localparam int CH_TWO_PIN    = 2;

   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 20;
   localparam int US_NS         = 1000;
   localparam int MS_NS         = 1000000;
   localparam int US_CYCLES     = US_NS / CLK_PERIOD_NS;
   localparam int MS_CYCLES     = MS_NS / CLK_PERIOD_NS;

   // ------------------------------------------------------------
   // width formats and full scales
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      FMT_HUNDREDTHS,
      FMT_THOUSANDTHS,
      FMT_TEN_THOUSANDTHS,
      FMT_ANALOG
   } width_format_type;

   localparam logic [15:0] FULL_HUNDREDTHS     = 16'h0064;
   localparam logic [15:0] FULL_THOUSANDTHS    = 16'h03E8;
   localparam logic [15:0] FULL_TEN_THOUSANDTHS = 16'h2710;
   localparam logic [15:0] FULL_ANALOG         = 16'h6C00;

   // ------------------------------------------------------------
   // control call
   // ------------------------------------------------------------
   localparam logic [15:0] STATUS_OK           = 16'h0000;
   localparam logic [15:0] STATUS_BAD_ID       = 16'h80A1;
   localparam logic [15:0] STATUS_RESET        = 16'h0000;
   localparam logic [15:0] WIDTH_RESET         = 16'h0000;
   // identifiers are arbitrary values
   localparam logic [15:0] CH_ONE_ID           = 16'h0001;
   localparam logic [15:0] CH_TWO_ID           = 16'h0002;

   typedef enum logic {
      CH_STOPPED,
      CH_RUNNING
   } channel_state_type;

endpackage : pwm_gen_pkg

// ===== rtl/dual_channel_pwm_generator.sv
// dual channel pulse width generator with start/stop control and pin ownership
`timescale 1ns/10ps
module dual_channel_pwm_generator
   import pwm_gen_pkg::*;
#(
   parameter int MS_TICK_CYCLES = MS_CYCLES                 // cycles per millisecond tick
)
(
   input  wire logic                        clk_sys_i,        // system clock, 50 MHz
   input  wire logic                        rst_i,            // async reset, active high
   input  wire logic                        run_mode_i,       // controller in run mode
   input  wire logic [CHANNELS-1:0]         gen_enable_i,     // generator enabled by config
   input  wire logic [CHANNELS-1:0]         pulse_train_mode_i, // generator given to train mode
   input  wire logic [CHANNELS-1:0]         output_source_i,  // 0 onboard, 1 add-on bank
   input  wire logic [CHANNELS-1:0]         time_base_us_i,   // 1 microseconds, 0 milliseconds
   input  wire logic [CHANNELS-1:0][1:0]    width_format_i,   // width full-scale format
   input  wire logic [CHANNELS-1:0][15:0]   cycle_time_i,     // static cycle time in ticks
   input  wire logic [CHANNELS-1:0][15:0]   init_width_i,     // width loaded on stop to run
   input  wire logic                        width_wr_i,       // write strobe for width word
   input  wire logic                        width_wr_sel_i,   // 0 channel one, 1 channel two
   input  wire logic [15:0]                 width_wr_data_i,  // new width value
   input  wire logic                        ctrl_exec_i,      // control call executes, pulse
   input  wire logic                        ctrl_en_i,        // enable-in of the call
   input  wire logic [15:0]                 ctrl_channel_i,   // channel identifier
   input  wire logic                        ctrl_enable_i,    // 1 start, 0 stop
   input  wire logic [BANK_PINS-1:0]        user_onboard_i,   // user program onboard values
   input  wire logic [BANK_PINS-1:0]        user_addon_i,     // user program add-on values
   input  wire logic [BANK_PINS-1:0]        force_onboard_en_i, // force request onboard
   input  wire logic [BANK_PINS-1:0]        force_onboard_val_i, // forced onboard value
   input  wire logic [BANK_PINS-1:0]        force_addon_en_i, // force request add-on
   input  wire logic [BANK_PINS-1:0]        force_addon_val_i, // forced add-on value
   output logic [15:0]                      channel_one_width_word_o, // width word, channel one
   output logic [15:0]                      channel_two_width_word_o, // width word, channel two
   output logic [CHANNELS-1:0]              running_o,        // channel running
   output logic                             busy_o,           // call busy, always low
   output logic [15:0]                      status_o,         // condition code of last call
   output logic                             enable_out_flag_o, // enable-out of last call
   output logic [BANK_PINS-1:0]             onboard_o,        // onboard physical pins
   output logic [BANK_PINS-1:0]             addon_o           // add-on physical pins
);

   // ------------------------------------------------------------
   // shared control decode
   // ------------------------------------------------------------
   logic                    run_mode_q;
   logic                    stop_to_run;
   logic [CHANNELS-1:0]     width_mode;
   logic [CHANNELS-1:0]     id_hit;
   logic [CHANNELS-1:0]     start_req;
   logic [CHANNELS-1:0]     stop_req;
   logic [CHANNELS-1:0]     pwm_raw;
   logic [CHANNELS-1:0][15:0] width_q;
   logic                    id_valid;
   logic [15:0]             status_q;
   logic                    eno_q;
   logic [BANK_PINS-1:0]    onboard_q;
   logic [BANK_PINS-1:0]    addon_q;

   // pin ownership per bank and the value each owned pin would show
   logic [BANK_PINS-1:0]    own_onboard;
   logic [BANK_PINS-1:0]    own_addon;
   logic [BANK_PINS-1:0]    drive_onboard;
   logic [BANK_PINS-1:0]    drive_addon;

   assign stop_to_run = run_mode_i & ~run_mode_q;
   assign width_mode  = gen_enable_i & ~pulse_train_mode_i;
   // a train-mode or disabled generator answers like an unknown identifier
   assign id_hit[0]   = (ctrl_channel_i == CH_ONE_ID) & width_mode[0];
   assign id_hit[1]   = (ctrl_channel_i == CH_TWO_ID) & width_mode[1];
   assign id_valid    = |id_hit;
   assign start_req   = {CHANNELS{ctrl_exec_i & ctrl_en_i & ctrl_enable_i}} & id_hit;
   assign stop_req    = {CHANNELS{ctrl_exec_i & ctrl_en_i & ~ctrl_enable_i}} & id_hit;

   // run mode is remembered one cycle to see the stop to run edge
   always_ff @(posedge clk_sys_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         run_mode_q <= 1'b0;
      end
      else
      begin
         run_mode_q <= run_mode_i;
      end
   end

   // ------------------------------------------------------------
   // width words
   // ------------------------------------------------------------
   // the reload wins over a user write in the same cycle, so run always starts from
   // the configured width
   always_ff @(posedge clk_sys_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         width_q <= {CHANNELS{WIDTH_RESET}};
      end
      else if (stop_to_run)
      begin
         width_q <= init_width_i;
      end
      else if (width_wr_i)
      begin
         width_q[width_wr_sel_i] <= width_wr_data_i;
      end
   end

   assign channel_one_width_word_o = width_q[0];
   assign channel_two_width_word_o = width_q[1];

   // ------------------------------------------------------------
   // control call answer
   // ------------------------------------------------------------
   // the request completes in the call cycle, so there is never a busy phase
   always_ff @(posedge clk_sys_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         status_q <= STATUS_RESET;
         eno_q    <= 1'b0;
      end
      else if (ctrl_exec_i)
      begin
         if (!ctrl_en_i)
         begin
            status_q <= STATUS_OK;
            eno_q    <= 1'b0;
         end
         else if (id_valid)
         begin
            status_q <= STATUS_OK;
            eno_q    <= 1'b1;
         end
         else
         begin
            status_q <= STATUS_BAD_ID;
            eno_q    <= 1'b0;
         end
      end
   end

   assign status_o          = status_q;
   assign enable_out_flag_o = eno_q;
   assign busy_o            = 1'b0;

   // ------------------------------------------------------------
   // channels
   // ------------------------------------------------------------
   for (genvar ch = 0; ch < CHANNELS; ch++)
   begin : g_ch
      channel_state_type state_q;

      // period position in ticks and the prescaler that makes each tick
      logic [15:0]       prescale_q;
      logic [15:0]       pos_q;
      logic [15:0]       high_q;

      // high time of the next period, from the current width word
      logic [15:0]       high_calc;
      logic [15:0]       full;
      logic [15:0]       wclamp;
      logic [31:0]       prod;

      // tick generation
      logic [15:0]       tick_last;
      logic              tick;

      always_comb
      begin
         case (width_format_type'(width_format_i[ch]))
            FMT_HUNDREDTHS:      full = FULL_HUNDREDTHS;
            FMT_THOUSANDTHS:     full = FULL_THOUSANDTHS;
            FMT_TEN_THOUSANDTHS: full = FULL_TEN_THOUSANDTHS;
            FMT_ANALOG:          full = FULL_ANALOG;
            default:             full = FULL_HUNDREDTHS;
         endcase
      end

      // clamping keeps the high time within the period
      assign wclamp    = (width_q[ch] > full) ? full : width_q[ch];
      assign prod      = 32'(cycle_time_i[ch]) * 32'(wclamp);
      // dividing by one of four constants keeps the divider small
      always_comb
      begin
         case (width_format_type'(width_format_i[ch]))
            FMT_HUNDREDTHS:      high_calc = 16'(prod / 32'(FULL_HUNDREDTHS));
            FMT_THOUSANDTHS:     high_calc = 16'(prod / 32'(FULL_THOUSANDTHS));
            FMT_TEN_THOUSANDTHS: high_calc = 16'(prod / 32'(FULL_TEN_THOUSANDTHS));
            FMT_ANALOG:          high_calc = 16'(prod / 32'(FULL_ANALOG));
            default:             high_calc = 16'(prod / 32'(FULL_HUNDREDTHS));
         endcase
      end

      // the microsecond tick is fixed; only the millisecond tick may be shortened
      assign tick_last = time_base_us_i[ch] ? 16'(US_CYCLES - 1)
                                            : 16'(MS_TICK_CYCLES - 1);
      assign tick      = (prescale_q == tick_last);

      always_ff @(posedge clk_sys_i or posedge rst_i)
      begin
         if (rst_i)
         begin
            state_q <= CH_STOPPED;
         end
         else
         begin
            case (state_q)
               CH_STOPPED:
               begin
                  // a start outside run mode is dropped, not held for later
                  if (start_req[ch] && run_mode_i)
                  begin
                     state_q <= CH_RUNNING;
                  end
               end
               CH_RUNNING:
               begin
                  // only a stop call, leaving run mode or losing the generator ends it
                  if (stop_req[ch] || !run_mode_i || !width_mode[ch])
                  begin
                     state_q <= CH_STOPPED;
                  end
               end
               default:
               begin
                  state_q <= CH_STOPPED;
               end
            endcase
         end
      end

      // period counter; cycle time is read only from static config
      // high time is latched at each period start so a width change never cuts a pulse
      always_ff @(posedge clk_sys_i or posedge rst_i)
      begin
         if (rst_i)
         begin
            prescale_q <= 16'h0000;
            pos_q      <= 16'h0000;
            high_q     <= 16'h0000;
         end
         else if (state_q != CH_RUNNING)
         begin
            prescale_q <= 16'h0000;
            pos_q      <= 16'h0000;
            high_q     <= high_calc;
         end
         else if (tick)
         begin
            prescale_q <= 16'h0000;
            if (pos_q + 16'h0001 >= cycle_time_i[ch])
            begin
               pos_q  <= 16'h0000;
               high_q <= high_calc;
            end
            else
            begin
               pos_q <= pos_q + 16'h0001;
            end
         end
         else
         begin
            prescale_q <= prescale_q + 16'h0001;
         end
      end

      // zero width never matches, full width always matches: no edges either way
      assign pwm_raw[ch]   = (state_q == CH_RUNNING) && (pos_q < high_q);
      assign running_o[ch] = (state_q == CH_RUNNING);
   end

   // ------------------------------------------------------------
   // pin ownership and output bank
   // ------------------------------------------------------------
   // both banks see the raw signal; ownership decides which one shows it
   always_comb
   begin
      own_onboard   = '0;
      own_addon     = '0;
      drive_onboard = '0;
      drive_addon   = '0;
      own_onboard[CH_ONE_PIN]   = width_mode[0] & ~output_source_i[0];
      own_addon[CH_ONE_PIN]     = width_mode[0] &  output_source_i[0];
      own_onboard[CH_TWO_PIN]   = width_mode[1] & ~output_source_i[1];
      own_addon[CH_TWO_PIN]     = width_mode[1] &  output_source_i[1];
      drive_onboard[CH_ONE_PIN] = pwm_raw[0];
      drive_addon[CH_ONE_PIN]   = pwm_raw[0];
      drive_onboard[CH_TWO_PIN] = pwm_raw[1];
      drive_addon[CH_TWO_PIN]   = pwm_raw[1];
   end

   // owned pins take the generator, free neighbours keep user and force paths
   always_ff @(posedge clk_sys_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         onboard_q <= '0;
      end
      else
      begin
         for (int p = 0; p < BANK_PINS; p++)
         begin
            if (own_onboard[p])
            begin
               onboard_q[p] <= drive_onboard[p];
            end
            else
            begin
               onboard_q[p] <= force_onboard_en_i[p] ? force_onboard_val_i[p]
                                                     : user_onboard_i[p];
            end
         end
      end
   end

   // the add-on bank has its own user and force paths
   always_ff @(posedge clk_sys_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         addon_q <= '0;
      end
      else
      begin
         for (int p = 0; p < BANK_PINS; p++)
         begin
            if (own_addon[p])
            begin
               addon_q[p] <= drive_addon[p];
            end
            else
            begin
               addon_q[p] <= force_addon_en_i[p] ? force_addon_val_i[p] : user_addon_i[p];
            end
         end
      end
   end

   assign onboard_o = onboard_q;
   assign addon_o   = addon_q;

endmodule : dual_channel_pwm_generator

// ===== tb/pwm_gen_monitor.sv
// concurrent checks on the ports of the dual channel pulse width generator
`timescale 1ns/10ps
module pwm_gen_monitor
   import pwm_gen_pkg::*;
(
   input wire logic                      clk_sys_i,                // system clock
   input wire logic                      rst_i,                    // async reset
   input wire logic                      run_mode_i,               // run mode
   input wire logic [CHANNELS-1:0]       gen_enable_i,             // generator enabled
   input wire logic [CHANNELS-1:0]       pulse_train_mode_i,       // train mode
   input wire logic [CHANNELS-1:0]       output_source_i,          // bank select
   input wire logic [CHANNELS-1:0][15:0] init_width_i,             // initial widths
   input wire logic                      ctrl_exec_i,              // call executes
   input wire logic                      ctrl_en_i,                // enable-in
   input wire logic [15:0]               ctrl_channel_i,           // channel id
   input wire logic                      ctrl_enable_i,            // start or stop
   input wire logic [BANK_PINS-1:0]      user_onboard_i,           // user values
   input wire logic [BANK_PINS-1:0]      force_onboard_en_i,       // force request
   input wire logic [BANK_PINS-1:0]      force_onboard_val_i,      // forced value
   input wire logic [15:0]               channel_one_width_word_o, // width word one
   input wire logic [CHANNELS-1:0]       running_o,                // channel state
   input wire logic                      busy_o,                   // busy
   input wire logic [15:0]               status_o,                 // condition code
   input wire logic                      enable_out_flag_o,        // enable-out
   input wire logic [BANK_PINS-1:0]      onboard_o                 // onboard pins
);
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);
   logic call_i, ok_one, own_one;
   assign call_i  = ctrl_exec_i && ctrl_en_i;
   assign ok_one  = gen_enable_i[0] && !pulse_train_mode_i[0];
   assign own_one = ok_one && !output_source_i[0];
   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   a_busy_never_set: assert property (busy_o == 1'b0)
      else $error("busy seen high");
   a_bad_id_code: assert property (call_i && ctrl_channel_i != CH_ONE_ID &&
      ctrl_channel_i != CH_TWO_ID |=> status_o == STATUS_BAD_ID && !enable_out_flag_o)
      else $error("bad identifier not refused");
   a_call_ok_one: assert property (call_i && ctrl_channel_i == CH_ONE_ID && ok_one
      |=> status_o == STATUS_OK && enable_out_flag_o)
      else $error("valid call on channel one flagged");
   a_call_disabled: assert property (ctrl_exec_i && !ctrl_en_i
      |=> status_o == STATUS_OK && !enable_out_flag_o)
      else $error("disabled call acted");
   a_start_one: assert property (call_i && ctrl_channel_i == CH_ONE_ID && ctrl_enable_i
      && ok_one && run_mode_i |=> running_o[0])
      else $error("channel one did not start");
   a_stop_one: assert property (call_i && ctrl_channel_i == CH_ONE_ID && !ctrl_enable_i
      |=> !running_o[0])
      else $error("channel one did not stop");
   a_reload_width: assert property ($rose(run_mode_i)
      |=> channel_one_width_word_o == $past(init_width_i[0]))
      else $error("width word not reloaded");
   a_owned_pin_low: assert property (!$past(rst_i) && $past(own_one && !running_o[0])
      |-> !onboard_o[0])
      else $error("stopped owned pin not low");
   a_free_pin_user: assert property (!$past(rst_i) |-> onboard_o[1] ==
      $past(force_onboard_en_i[1] ? force_onboard_val_i[1] : user_onboard_i[1]))
      else $error("free pin not from user or force");
   c_start: cover property (call_i && ctrl_enable_i ##1 running_o[0]);
   c_bad: cover property (status_o == STATUS_BAD_ID);
   c_pulse: cover property ($rose(onboard_o[0]));
endmodule : pwm_gen_monitor

bind dual_channel_pwm_generator pwm_gen_monitor u_mon (.clk_sys_i(clk_sys_i),
   .rst_i(rst_i), .run_mode_i(run_mode_i), .gen_enable_i(gen_enable_i),
   .pulse_train_mode_i(pulse_train_mode_i), .output_source_i(output_source_i),
   .init_width_i(init_width_i), .ctrl_exec_i(ctrl_exec_i), .ctrl_en_i(ctrl_en_i),
   .ctrl_channel_i(ctrl_channel_i), .ctrl_enable_i(ctrl_enable_i),
   .user_onboard_i(user_onboard_i), .force_onboard_en_i(force_onboard_en_i),
   .force_onboard_val_i(force_onboard_val_i),
   .channel_one_width_word_o(channel_one_width_word_o), .running_o(running_o),
   .busy_o(busy_o), .status_o(status_o), .enable_out_flag_o(enable_out_flag_o),
   .onboard_o(onboard_o));

// ===== tb/dual_channel_pwm_generator_bench.sv
// self-checking bench for the dual channel pulse width generator
`timescale 1ns/10ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_errors++; \
   $display("[ERR] %s expected %0h seen %0h", nm, e, g); end end
module dual_channel_pwm_generator_bench
   import pwm_gen_pkg::*;
;
   // ------------------------------------------------------------
   // signals
   // ------------------------------------------------------------
   localparam int TICK = 10;          // shortened millisecond tick
   logic            clk_sys_i, rst_i, run_mode_i, width_wr_i, width_wr_sel_i;
   logic            ctrl_exec_i, ctrl_en_i, ctrl_enable_i, busy_o, enable_out_flag_o;
   logic [1:0]      gen_enable_i, pulse_train_mode_i, output_source_i, time_base_us_i;
   logic [1:0]      running_o;
   logic [1:0][1:0] width_format_i;
   logic [1:0][15:0] cycle_time_i, init_width_i;
   logic [15:0]     width_wr_data_i, ctrl_channel_i, status_o;
   logic [15:0]     channel_one_width_word_o, channel_two_width_word_o;
   logic [3:0]      user_onboard_i, user_addon_i, force_onboard_en_i, force_onboard_val_i;
   logic [3:0]      force_addon_en_i, force_addon_val_i, onboard_o, addon_o;
   int              n_errors = 0;
   int              tests_run = 0;
   int              k, full;
   logic [15:0]     wtab [8] = '{16'h001E, 16'h012C, 16'h0BB8, 16'h2066,
                                 16'h0000, 16'h0064, 16'h00C8, 16'h0037};
   logic [1:0]      ftab [8] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0, 2'h0, 2'h0, 2'h0};

   dual_channel_pwm_generator #(.MS_TICK_CYCLES(TICK)) dut (.clk_sys_i(clk_sys_i),
      .rst_i(rst_i), .run_mode_i(run_mode_i), .gen_enable_i(gen_enable_i),
      .pulse_train_mode_i(pulse_train_mode_i), .output_source_i(output_source_i),
      .time_base_us_i(time_base_us_i), .width_format_i(width_format_i),
      .cycle_time_i(cycle_time_i), .init_width_i(init_width_i), .width_wr_i(width_wr_i),
      .width_wr_sel_i(width_wr_sel_i), .width_wr_data_i(width_wr_data_i),
      .ctrl_exec_i(ctrl_exec_i), .ctrl_en_i(ctrl_en_i), .ctrl_channel_i(ctrl_channel_i),
      .ctrl_enable_i(ctrl_enable_i), .user_onboard_i(user_onboard_i),
      .user_addon_i(user_addon_i), .force_onboard_en_i(force_onboard_en_i),
      .force_onboard_val_i(force_onboard_val_i), .force_addon_en_i(force_addon_en_i),
      .force_addon_val_i(force_addon_val_i),
      .channel_one_width_word_o(channel_one_width_word_o),
      .channel_two_width_word_o(channel_two_width_word_o), .running_o(running_o),
      .busy_o(busy_o), .status_o(status_o), .enable_out_flag_o(enable_out_flag_o),
      .onboard_o(onboard_o), .addon_o(addon_o));

   // ------------------------------------------------------------
   // access tasks
   // ------------------------------------------------------------
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : end_of_test

   task automatic call(input logic [15:0] id, input logic en, input logic enable);
      @(posedge clk_sys_i);
      ctrl_exec_i    <= 1'b1;
      ctrl_en_i      <= en;
      ctrl_channel_i <= id;
      ctrl_enable_i  <= enable;
      @(posedge clk_sys_i);
      ctrl_exec_i    <= 1'b0;
      #1;
      `CHK("busy", 1'b0, busy_o)
   endtask : call

   task automatic wr(input logic sel, input logic [15:0] data);
      @(posedge clk_sys_i);
      width_wr_i      <= 1'b1;
      width_wr_sel_i  <= sel;
      width_wr_data_i <= data;
      @(posedge clk_sys_i);
      width_wr_i      <= 1'b0;
      #1;
   endtask : wr

   // counts high cycles over a window; a whole period gives the high time
   task automatic measure(input logic addon, input int bit_n, input int n, output int cnt);
      cnt = 0;
      repeat (n)
      begin
         @(posedge clk_sys_i);
         #1;
         if ((addon ? addon_o[bit_n] : onboard_o[bit_n]) === 1'b1)
            cnt++;
      end
   endtask : measure

   // ------------------------------------------------------------
   // clock, watchdog, sequence
   // ------------------------------------------------------------
   initial
   begin
      clk_sys_i = 1'b0;
      forever #10 clk_sys_i = ~clk_sys_i;
   end

   initial
   begin
      repeat (100000) @(posedge clk_sys_i);
      n_errors++;
      end_of_test();
   end

   initial
   begin
      rst_i = 1'b1; run_mode_i = 1'b1; width_wr_i = 1'b0; width_wr_sel_i = 1'b0;
      ctrl_exec_i = 1'b0; ctrl_en_i = 1'b0; ctrl_enable_i = 1'b0;
      gen_enable_i = 2'h3; pulse_train_mode_i = 2'h0; output_source_i = 2'h2;
      time_base_us_i = 2'h2; width_format_i = {2'h3, 2'h0};
      cycle_time_i = {16'h0032, 16'h000A}; init_width_i = {16'h1B00, 16'h001E};
      width_wr_data_i = 16'h0000; ctrl_channel_i = 16'h0000;
      user_onboard_i = 4'hD; user_addon_i = 4'hF; force_onboard_en_i = 4'hF;
      force_onboard_val_i = 4'h3; force_addon_en_i = 4'h0; force_addon_val_i = 4'h0;
      repeat (5) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      repeat (3) @(posedge clk_sys_i);
      #1;
      `CHK("word one init", 16'h001E, channel_one_width_word_o)
      `CHK("word two init", 16'h1B00, channel_two_width_word_o)
      call(16'h0003, 1'b1, 1'b1);
      `CHK("status bad id", STATUS_BAD_ID, status_o)
      `CHK("eno bad id", 1'b0, enable_out_flag_o)
      call(CH_ONE_ID, 1'b0, 1'b1);
      `CHK("status en low", STATUS_OK, status_o)
      `CHK("running en low", 2'h0, running_o)
      repeat (2) @(posedge clk_sys_i);
      #1;
      `CHK("owned pin forced", 1'b0, onboard_o[0])
      `CHK("free pin forced", 1'b1, onboard_o[1])
      `CHK("addon free pin", 1'b1, addon_o[0])
      call(CH_ONE_ID, 1'b1, 1'b1);
      `CHK("eno start", 1'b1, enable_out_flag_o)
      call(CH_TWO_ID, 1'b1, 1'b1);
      `CHK("running both", 2'h3, running_o)
      repeat (400) @(posedge clk_sys_i);
      measure(1'b1, 2, 2500, k);
      `CHK("ch2 high us analog", 600, k)
      `CHK("ch2 bank other pin", 1'b0, onboard_o[2])
      // widths across all formats, then zero, full scale and above full scale
      for (int i = 0; i < 8; i++)
      begin
         width_format_i[0] <= ftab[i];
         wr(1'b0, wtab[i]);
         `CHK("word one write", wtab[i], channel_one_width_word_o)
         case (ftab[i])
            2'h0: full = 100;
            2'h1: full = 1000;
            2'h2: full = 10000;
            default: full = 27648;
         endcase
         repeat (200) @(posedge clk_sys_i);
         measure(1'b0, 0, 10 * TICK, k);
         full = ((10 * (wtab[i] > full ? full : wtab[i])) / full) * TICK;
         `CHK("ch1 high", full, k)
      end
      call(CH_ONE_ID, 1'b1, 1'b0);
      `CHK("running after stop", 2'h2, running_o)
      repeat (3) @(posedge clk_sys_i);
      #1;
      `CHK("pin after stop", 1'b0, onboard_o[0])
      run_mode_i <= 1'b0;
      repeat (2) @(posedge clk_sys_i);
      run_mode_i <= 1'b1;
      repeat (3) @(posedge clk_sys_i);
      #1;
      `CHK("word one reload", 16'h001E, channel_one_width_word_o)
      pulse_train_mode_i <= 2'h2;
      gen_enable_i       <= 2'h2;
      call(CH_TWO_ID, 1'b1, 1'b1);
      `CHK("status train mode", STATUS_BAD_ID, status_o)
      `CHK("eno train mode", 1'b0, enable_out_flag_o)
      call(CH_TWO_ID, 1'b0, 1'b1);
      `CHK("status en low again", STATUS_OK, status_o)
      call(CH_ONE_ID, 1'b1, 1'b1);
      `CHK("status disabled gen", STATUS_BAD_ID, status_o)
      `CHK("eno disabled gen", 1'b0, enable_out_flag_o)
      end_of_test();
   end
endmodule : dual_channel_pwm_generator_bench
